// file: verif/fdc_host_transfer_handshake_tb.sv
// Self-checking bench of the floppy host transfer handshake
`timescale 1ns/100ps
`default_nettype none
module fdc_host_transfer_handshake_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        wrStrobe = 1'b0;
	logic        rdStrobe = 1'b0;
	logic [7:0]  wrData = 8'h00;
	logic        go = 1'b0;
	logic        slow = 1'b0;
	logic [7:0]  nBytes = 8'h00;
	logic [7:0]  rdData, mainStatus, trackNum, sectorNum, diskByte, v;
	logic [1:0]  driveSel;
	logic        intReq, startRead, headSel, doubleDensity, skipDeleted;
	logic        diskValid, diskReady, sectorEnd;
	logic        sawFull = 1'b0;
	int          fails = 0;
	int          n_tests = 0;
	int          starts = 0;
	logic [23:0] rows [4] = '{24'h12D080, 24'h00D080, 24'h1FD080, 24'h07D080};
	logic [7:0]  res [7] = '{8'h00, 8'h00, 8'h00, 8'h12, 8'h01, 8'h03, 8'h02};
	logic [7:0]  prm [8] = '{8'h05, 8'h12, 8'h01, 8'h03, 8'h02, 8'h0F, 8'h1B, 8'hFF};

	always #10 clk = ~clk;
	always @(negedge clk) if (startRead === 1'b1) starts++;
	always @(negedge clk) if (diskReady === 1'b0) sawFull = 1'b1;

	fdcth_top u_dut (.clk(clk), .rst_n(rst_n), .wrStrobe(wrStrobe), .wrData(wrData),
		.rdStrobe(rdStrobe), .rdData(rdData), .mainStatus(mainStatus), .intReq(intReq),
		.startRead(startRead), .driveSel(driveSel), .headSel(headSel),
		.doubleDensity(doubleDensity), .skipDeleted(skipDeleted), .trackNum(trackNum),
		.sectorNum(sectorNum), .diskValid(diskValid), .diskByte(diskByte),
		.diskReady(diskReady), .sectorEnd(sectorEnd));

	fdcth_drive_model u_drive (.clk(clk), .rst_n(rst_n), .go(go), .nBytes(nBytes),
		.firstByte(8'hA0), .slow(slow), .diskValid(diskValid), .diskByte(diskByte),
		.diskReady(diskReady), .sectorEnd(sectorEnd));

	// =====
	// Host tasks
	task automatic final_report();
		$display("tests=%0d fails=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic waitMs(input logic [7:0] e);
		for (int k = 0; k < 3000 && mainStatus !== e; k++) @(negedge clk);
		if (mainStatus !== e) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, mainStatus, e);
			final_report();
		end
	endtask

	task automatic wr(input logic [7:0] d);
		@(negedge clk);
		wrStrobe = 1'b1;
		wrData = d;
		@(negedge clk);
		wrStrobe = 1'b0;
	endtask

	task automatic rd(output logic [7:0] d);
		@(negedge clk);
		rdStrobe = 1'b1;
		d = rdData;
		@(negedge clk);
		rdStrobe = 1'b0;
	endtask

	task automatic cmd(input logic [7:0] op);
		waitMs(8'h80);
		wr(op);
		foreach (prm[i]) begin
			// Busy already up once the opcode is taken
			waitMs(8'h90);
			wr(prm[i]);
		end
	endtask

	task automatic sector(input logic [7:0] n, input logic s);
		@(negedge clk);
		go = 1'b1;
		nBytes = n;
		slow = s;
		@(negedge clk);
		go = 1'b0;
	endtask

	task automatic results(input logic [7:0] st0, input logic [7:0] st1);
		waitMs(8'hD0);
		chk({7'h00, intReq}, 8'h01);
		chk(rdData, st0);
		for (int i = 0; i < 7; i++) begin
			rd(v);
			chk(v, (i == 0) ? st0 : (i == 1) ? st1 : res[i]);
			if (i == 0) chk({7'h00, intReq}, 8'h00);
		end
		chk(mainStatus, 8'h80);
	endtask

	// =====
	// Sequence
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		chk(mainStatus, 8'h80);
		chk({7'h00, intReq}, 8'h00);
		chk({7'h00, diskReady}, 8'h01);
		foreach (rows[r]) begin
			wr(rows[r][23:16]);
			chk(mainStatus, rows[r][15:8]);
			chk(rdData, rows[r][7:0]);
			chk({7'h00, intReq}, 8'h00);
			rd(v);
			chk(v, rows[r][7:0]);
			chk(mainStatus, 8'h80);
		end
		// Top three opcode bits are masked off, so E6h is a read
		cmd(8'hE6);
		chk(mainStatus, 8'h30);
		chk({6'h00, driveSel}, 8'h01);
		chk({4'h0, doubleDensity, skipDeleted, headSel, 1'b0}, 8'h0E);
		chk(trackNum, 8'h12);
		chk(sectorNum, 8'h03);
		wr(8'h12);
		chk(mainStatus, 8'h30);
		chk(8'(starts), 8'h01);
		sector(8'd20, 1'b0);
		repeat (60) @(negedge clk);
		chk({7'h00, sawFull}, 8'h01);
		for (int i = 0; i < 20; i++) begin
			waitMs(8'hF0);
			chk({7'h00, intReq}, 8'h01);
			chk(rdData, 8'hA0 + 8'(i));
			rd(v);
			chk(v, 8'hA0 + 8'(i));
			chk({7'h00, intReq}, 8'h00);
			chk({7'h00, mainStatus[7]}, 8'h00);
		end
		results(8'h05, 8'h00);
		cmd(8'hE6);
		sector(8'd2, 1'b1);
		waitMs(8'hF0);
		// Host stalls past the 600-cycle service time
		repeat (700) @(negedge clk);
		results(8'h45, 8'h10);
		final_report();
	end
endmodule
`default_nettype wire

// file: verif/fdcth_drive_model.sv
// Drive-side byte source feeding the controller FIFO
`timescale 1ns/100ps
`default_nettype none

// =====
// Drive model
module fdcth_drive_model (
	input  wire logic       clk,       // Clock
	input  wire logic       rst_n,     // Reset, low
	input  wire logic       go,        // Start sector
	input  wire logic [7:0] nBytes,    // Sector bytes
	input  wire logic [7:0] firstByte, // First value
	input  wire logic       slow,      // Gap per byte
	output logic            diskValid, // Byte offered
	output logic [7:0]      diskByte,  // Byte
	input  wire logic       diskReady, // Byte taken
	output logic            sectorEnd  // Sector done
);
	logic [7:0] left_r;
	logic [7:0] next_r;
	logic [1:0] gap_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			diskValid <= 1'b0;
			diskByte <= 8'h00;
			sectorEnd <= 1'b0;
			left_r <= 8'h00;
			next_r <= 8'h00;
			gap_r <= 2'h0;
		end else begin
			sectorEnd <= 1'b0;
			if (go) begin
				left_r <= nBytes;
				diskByte <= firstByte;
				next_r <= firstByte + 8'h01;
				diskValid <= 1'b1;
			end else if (diskValid && diskReady) begin
				// Released data shows the inverse, never the old byte
				left_r <= left_r - 8'h01;
				diskValid <= 1'b0;
				diskByte <= ~diskByte;
				gap_r <= slow ? 2'h3 : 2'h0;
				sectorEnd <= (left_r == 8'h01);
			end else if (!diskValid && left_r != 8'h00) begin
				if (gap_r != 2'h0) begin
					gap_r <= gap_r - 2'h1;
				end else begin
					diskValid <= 1'b1;
					diskByte <= next_r;
					next_r <= next_r + 8'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: verilog/fdcth_cfg.svh
// Constants of the floppy host transfer handshake
`ifndef FDCTH_CFG_SVH
`define FDCTH_CFG_SVH
`define FDCTH_CLK_MHZ       50
`define FDCTH_SVC_NS        12000
`define FDCTH_SVC_CYC       ((`FDCTH_SVC_NS * `FDCTH_CLK_MHZ) / 1000)
`define FDCTH_FIFO_DEPTH    16
`define FDCTH_NUM_PARAMS    8
`define FDCTH_OP_MASK       8'h1F
`define FDCTH_OP_READ       8'h06
`define FDCTH_BAD_RESULT    8'h80
`define FDCTH_RES_LAST_RD   3'h6
`define FDCTH_MSR_RQM       7
`define FDCTH_MSR_DIO       6
`define FDCTH_MSR_EXM       5
`define FDCTH_MSR_BUSY      4
`define FDCTH_ST1_OVERRUN   4
`define FDCTH_ST0_ABNORMAL  2'h1
`endif

// file: verilog/fdcth_pkg.sv
// Types of the floppy host transfer handshake
package fdcth_pkg;
	typedef enum logic [2:0] {ST_CMD, ST_PARAM, ST_EXEC, ST_LATCH, ST_RESULT} fdcth_state_e;
	typedef struct packed {
		fdcth_state_e     state;
		logic [2:0]       pIdx;
		logic             doubleDensity;
		logic             skipDeleted;
		logic             headSel;
		logic [1:0]       driveSel;
		logic [7:0]       track;
		logic [7:0]       headNum;
		logic [7:0]       sector;
		logic [7:0]       sizeCode;
		logic             byteWait;
		logic [9:0]       svcCnt;
		logic             overrun;
		logic             sectorDone;
		logic             resInt;
		logic [2:0]       resIdx;
		logic [2:0]       resLast;
		logic [0:6][7:0]  res;
		logic [7:0]       rdData;
		logic [7:0]       main_status_reg;
		logic             intReq;
		logic             startRead;
	} fdcth_regs_s;
endpackage

// file: verilog/fdcth_top.sv
// Floppy controller host transfer handshake with its drive-side FIFO
// Behaviour
// - Non-DMA execution raises the interrupt whenever a data byte waits for the host.
// - A waiting execution byte shows status bits 5 and 7 set.
// - The byte interrupt drops once the host reads that byte.
// - An unserviced byte flags overrun; command ends at sector end, overrun in results.
// - After the last byte, interrupt with status bits 7,6 set and 5 clear.
// - Reading the first result byte removes the result interrupt.
// - Status bit 7 mirrors the interrupt output during execution.
// - Command bytes accepted only in command phase; first byte checked as opcode.
// - Bad opcode: request, direction and busy set, single result byte 80H.
// - After reading the bad-opcode result, back to command phase.
// - Execution starts right after the last parameter byte is written.
`timescale 1ns/100ps
`default_nettype none
`include "fdcth_cfg.svh"

// ==========================================================
// FIFO
module fdcth_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input  wire logic         clk,      // System clock
	input  wire logic         rst_n,    // Async reset, low
	input  wire logic         inValid,  // Source offers a word
	output logic              inReady,  // Room for a word
	input  wire logic [W-1:0] inData,   // Word in
	output logic              outValid, // Word available
	input  wire logic         outReady, // Sink takes the word
	output logic [W-1:0]      outData   // Head word
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
		logic                room;
	} fdcth_fifo_s;
	fdcth_fifo_s s_r;
	fdcth_fifo_s s_nxt;
	logic        push;
	logic        pop;

	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	// Registered room flag, so the ready output comes straight from a flop
	assign inReady = s_r.room;
	assign outValid = (s_r.cnt != '0);
	assign outData = s_r.mem[s_r.rp];

	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = inData;
			s_nxt.wp = (s_r.wp == AW'(D-1)) ? '0 : s_r.wp + 1'b1;
		end
		if (pop)
			s_nxt.rp = (s_r.rp == AW'(D-1)) ? '0 : s_r.rp + 1'b1;
		s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
		s_nxt.room = (s_nxt.cnt != (AW+1)'(D));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			s_r <= '{room: 1'b1, default: '0};
		else
			s_r <= s_nxt;
	end
endmodule

// ==========================================================
// Handshake core
module fdcth_top (
	input  wire logic       clk,           // 50 MHz system clock
	input  wire logic       rst_n,         // Async reset, low
	input  wire logic       wrStrobe,      // Host writes data register
	input  wire logic [7:0] wrData,        // Host write byte
	input  wire logic       rdStrobe,      // Host reads data register
	output logic [7:0]      rdData,        // Data register read value
	output logic [7:0]      mainStatus,    // Main status register
	output logic            intReq,        // Interrupt output
	output logic            startRead,     // Pulse: read command begins
	output logic [1:0]      driveSel,      // Drive select bits
	output logic            headSel,       // Head select bit
	output logic            doubleDensity, // Density flag
	output logic            skipDeleted,   // Skip flag
	output logic [7:0]      trackNum,      // Track parameter
	output logic [7:0]      sectorNum,     // Sector parameter
	input  wire logic       diskValid,     // Drive byte offered
	input  wire logic [7:0] diskByte,      // Drive byte
	output logic            diskReady,     // FIFO has room
	input  wire logic       sectorEnd      // Pulse: sector finished
);
	import fdcth_pkg::*;

	fdcth_regs_s s_r;
	fdcth_regs_s s_nxt;
	logic        fifoValid;
	logic [7:0]  fifoData;
	logic        pop;

	function automatic logic validOp(input logic [7:0] op);
		return (op & `FDCTH_OP_MASK) == `FDCTH_OP_READ;
	endfunction

	function automatic logic [7:0] msrOf(input fdcth_regs_s r);
		logic [7:0] m;
		m = 8'h00;
		unique case (r.state)
			ST_CMD, ST_PARAM: m[`FDCTH_MSR_RQM] = 1'b1;
			ST_EXEC: begin
				m[`FDCTH_MSR_RQM] = r.byteWait;
				m[`FDCTH_MSR_DIO] = r.byteWait;
				m[`FDCTH_MSR_EXM] = 1'b1;
			end
			ST_LATCH: m[`FDCTH_MSR_RQM] = 1'b0;
			ST_RESULT: begin
				m[`FDCTH_MSR_RQM] = 1'b1;
				m[`FDCTH_MSR_DIO] = 1'b1;
			end
		endcase
		m[`FDCTH_MSR_BUSY] = (r.state != ST_CMD);
		return m;
	endfunction

	fdcth_fifo #(
		.W (8),
		.D (`FDCTH_FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.rst_n    (rst_n),
		.inValid  (diskValid),
		.inReady  (diskReady),
		.inData   (diskByte),
		.outValid (fifoValid),
		.outReady (pop),
		.outData  (fifoData)
	);

	// ==========================================================
	// Execution byte service
	assign pop = (s_r.state == ST_EXEC) &&
		((s_r.byteWait && rdStrobe) || (s_r.overrun && fifoValid));

	always_comb begin
		s_nxt = s_r;
		s_nxt.startRead = 1'b0;
		unique case (s_r.state)
			ST_CMD: begin
				if (wrStrobe) begin
					if (validOp(wrData)) begin
						s_nxt.doubleDensity = wrData[6];
						s_nxt.skipDeleted = wrData[5];
						s_nxt.pIdx = 3'h0;
						s_nxt.state = ST_PARAM;
					end else begin
						s_nxt.res[0] = `FDCTH_BAD_RESULT;
						s_nxt.resIdx = 3'h0;
						s_nxt.resLast = 3'h0;
						s_nxt.resInt = 1'b0;
						s_nxt.state = ST_RESULT;
					end
				end
			end
			ST_PARAM: begin
				if (wrStrobe) begin
					unique case (s_r.pIdx)
						3'h0: begin
							s_nxt.headSel = wrData[2];
							s_nxt.driveSel = wrData[1:0];
						end
						3'h1: s_nxt.track = wrData;
						3'h2: s_nxt.headNum = wrData;
						3'h3: s_nxt.sector = wrData;
						3'h4: s_nxt.sizeCode = wrData;
						default: ;
					endcase
					s_nxt.pIdx = s_r.pIdx + 3'h1;
					if (s_r.pIdx == 3'(`FDCTH_NUM_PARAMS - 1)) begin
						s_nxt.state = ST_EXEC;
						s_nxt.startRead = 1'b1;
						s_nxt.overrun = 1'b0;
						s_nxt.sectorDone = 1'b0;
						s_nxt.svcCnt = '0;
					end
				end
			end
			ST_EXEC: begin
				s_nxt.byteWait = fifoValid && !pop && !s_r.overrun;
				if (!s_r.byteWait || pop)
					s_nxt.svcCnt = '0;
				else if (s_r.svcCnt == 10'(`FDCTH_SVC_CYC - 1))
					s_nxt.overrun = 1'b1;
				else
					s_nxt.svcCnt = s_r.svcCnt + 10'h1;
				if (sectorEnd)
					s_nxt.sectorDone = 1'b1;
				if (s_r.sectorDone && !fifoValid && !s_r.byteWait)
					s_nxt.state = ST_LATCH;
			end
			ST_LATCH: begin
				s_nxt.res[0] = {s_r.overrun ? `FDCTH_ST0_ABNORMAL : 2'h0, 3'h0, s_r.headSel, s_r.driveSel};
				s_nxt.res[1] = 8'h00;
				s_nxt.res[1][`FDCTH_ST1_OVERRUN] = s_r.overrun;
				s_nxt.res[2] = 8'h00;
				s_nxt.res[3] = s_r.track;
				s_nxt.res[4] = s_r.headNum;
				s_nxt.res[5] = s_r.sector;
				s_nxt.res[6] = s_r.sizeCode;
				s_nxt.resIdx = 3'h0;
				s_nxt.resLast = `FDCTH_RES_LAST_RD;
				s_nxt.resInt = 1'b1;
				s_nxt.state = ST_RESULT;
			end
			ST_RESULT: begin
				if (rdStrobe) begin
					s_nxt.resInt = 1'b0;
					// Wrap the index so the read mux never leaves the result array
					if (s_r.resIdx == s_r.resLast) begin
						s_nxt.resIdx = 3'h0;
						s_nxt.state = ST_CMD;
					end else begin
						s_nxt.resIdx = s_r.resIdx + 3'h1;
					end
				end
			end
		endcase
		if (s_nxt.state != ST_EXEC)
			s_nxt.byteWait = 1'b0;
		s_nxt.rdData = (s_nxt.state == ST_EXEC) ? fifoData : s_nxt.res[s_nxt.resIdx];
		s_nxt.intReq = (s_nxt.state == ST_EXEC && s_nxt.byteWait) ||
			(s_nxt.state == ST_RESULT && s_nxt.resInt);
		s_nxt.main_status_reg = msrOf(s_nxt);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			s_r <= '{state: ST_CMD, main_status_reg: 8'h80, default: '0};
		else
			s_r <= s_nxt;
	end

	assign rdData = s_r.rdData;
	assign mainStatus = s_r.main_status_reg;
	assign intReq = s_r.intReq;
	assign startRead = s_r.startRead;
	assign driveSel = s_r.driveSel;
	assign headSel = s_r.headSel;
	assign doubleDensity = s_r.doubleDensity;
	assign skipDeleted = s_r.skipDeleted;
	assign trackNum = s_r.track;
	assign sectorNum = s_r.sector;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_byteInt;
		s_r.state == ST_EXEC && s_r.byteWait |-> intReq;
	endproperty
	a_byteInt: assert property (p_byteInt) else $error("byte wait without interrupt");
	property p_byteBits;
		s_r.byteWait |-> mainStatus[7] && mainStatus[5];
	endproperty
	a_byteBits: assert property (p_byteBits) else $error("bits 7/5 not set");
	property p_byteClr;
		s_r.byteWait && rdStrobe |=> !intReq;
	endproperty
	a_byteClr: assert property (p_byteClr) else $error("byte interrupt not dropped");
	property p_overrun;
		s_r.state == ST_LATCH && s_r.overrun |=> s_r.res[1][4] && s_r.res[0][7:6] == 2'h1;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not reported");
	property p_resBits;
		s_r.state == ST_RESULT && s_r.resInt |-> intReq && mainStatus[7:5] == 3'h6;
	endproperty
	a_resBits: assert property (p_resBits) else $error("result entry status wrong");
	property p_resClr;
		s_r.state == ST_RESULT && rdStrobe |=> !intReq;
	endproperty
	a_resClr: assert property (p_resClr) else $error("result interrupt kept");
	property p_mirror;
		s_r.state == ST_EXEC |-> mainStatus[7] == intReq;
	endproperty
	a_mirror: assert property (p_mirror) else $error("bit 7 differs from interrupt");
	property p_noCmd;
		s_r.state inside {ST_EXEC, ST_LATCH} && wrStrobe |=> $stable(s_r.track) && $stable(s_r.pIdx);
	endproperty
	a_noCmd: assert property (p_noCmd) else $error("write taken outside command phase");
	property p_badOp;
		s_r.state == ST_CMD && wrStrobe && !validOp(wrData) |=> mainStatus[7:4] == 4'hD && rdData == 8'h80;
	endproperty
	a_badOp: assert property (p_badOp) else $error("bad opcode answer wrong");
	property p_badBack;
		s_r.state == ST_RESULT && s_r.resLast == 3'h0 && rdStrobe |=> s_r.state == ST_CMD ##0 mainStatus[7:4] == 4'h8;
	endproperty
	a_badBack: assert property (p_badBack) else $error("no return to command phase");
	property p_start;
		s_r.state == ST_PARAM && s_r.pIdx == 3'h7 && wrStrobe |=> s_r.state == ST_EXEC && startRead;
	endproperty
	a_start: assert property (p_start) else $error("execution did not start");
	property p_latchFirst;
		s_r.state == ST_LATCH |-> !intReq ##1 intReq;
	endproperty
	a_latchFirst: assert property (p_latchFirst) else $error("result interrupt timing wrong");

	c_read: cover property (startRead ##[1:200] s_r.state == ST_RESULT);
	c_overrun: cover property (s_r.state == ST_LATCH && s_r.overrun);
	c_badOp: cover property (s_r.state == ST_RESULT && s_r.resLast == 3'h0 && rdStrobe);
endmodule
`default_nettype wire
